// file: design/rfi_consts.svh
// Offsets, field positions and reset values of the rail fault interrupt block.
// Assumes a byte address of eight bits on the register port, one word per register.
//
// Overview of operation
// [RQ1] Current-limit event triggers sequencing only when trigger enable is set; interrupt always.
// [RQ2] Current-limit flag clears on write one, has mask and live bit, holds while active.
// [RQ3] Short circuit disables rail, sets short flag, triggers by group; no mask or live.
// [RQ4] Short flag clear is refused while rail enabled, ramped and still below threshold.
// [RQ5] Residual voltage with select set acts like a short; with select clear ignored.
// [RQ6] Residual-caused short flag reads only after residual gone and power-up completed.
// [RQ7] Buck over and under flags: mask, live bit, write-one clear, hold while fault.
// [RQ8] Input supply over and under flags: mask, live, group routing, hold while fault.
// [RQ9] Each monitor over and under flags: mask, live, group routing, hold while fault.
// [RQ10] Monitor residual with select set triggers and sets unmaskable flag; else ignored.
// [RQ11] Fault triggers route through per-source group select and per-group trigger bits.
// [RQ12] Masked events never set a flag; an already set flag stays until cleared.
// [RQ13] All flags combine into one active-low interrupt; flags keep source until cleared.
// [RQ14] Host reads live bit before clearing; a clear is void while the fault shows.
`ifndef RFI_CONSTS_SVH
`define RFI_CONSTS_SVH

`define RFI_ADDR_BUCK_FLAG  8'h00
`define RFI_ADDR_MON_FLAG   8'h04
`define RFI_ADDR_BUCK_MASK  8'h08
`define RFI_ADDR_MON_MASK   8'h0c
`define RFI_ADDR_BUCK_LIVE  8'h10
`define RFI_ADDR_MON_LIVE   8'h14
`define RFI_ADDR_CONFIG     8'h18
`define RFI_ADDR_GROUP      8'h1c
`define RFI_ADDR_RAIL_TRIG  8'h20
`define RFI_ADDR_IRQ_EN     8'h24
`define RFI_ADDR_CLR_BUCK   8'h28
`define RFI_ADDR_CLR_MON    8'h2c

`define RFI_SHORT_FIELD     16'h00f0
`define RFI_RST_MASK        16'h0000
`define RFI_RST_IRQ_EN      24'hffffff

`endif

// file: design/rfi_pkg.sv
// Types shared by the rail fault interrupt block.
// Assumes the constants header is included by the files that need offsets.
`default_nettype none
package rfi_pkg;
  typedef logic [31:0] rfi_word_t;
  typedef logic [1:0]  rfi_group_t;
endpackage
`default_nettype wire

// file: design/rail_fault_interrupt_logic.sv
// Fault interrupt logic for four buck rails, the input supply and two voltage monitors.
// Assumes fault pins are asynchronous comparator outputs and rail state comes from the same clock.
//
// Local design decisions: strobed register access and the register addresses.
`include "rfi_consts.svh"
`default_nettype none
module rail_fault_interrupt_logic (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  // Buck fault comparator pins.
  input  wire logic [3:0]  buckIlimPin,
  input  wire logic [3:0]  buckShortPin,
  input  wire logic [3:0]  buckResidualPin,
  input  wire logic [3:0]  buckOverPin,
  input  wire logic [3:0]  buckUnderPin,
  // Rail state from the regulator control.
  input  wire logic [3:0]  buckEnabled,
  input  wire logic [3:0]  buckRampDone,
  input  wire logic [3:0]  buckBelowShort,
  input  wire logic        powerUpDone,
  // Input supply and monitor pins.
  input  wire logic        vccaOverPin,
  input  wire logic        vccaUnderPin,
  input  wire logic [1:0]  monOverPin,
  input  wire logic [1:0]  monUnderPin,
  input  wire logic [1:0]  monResidualPin,
  // Results.
  output logic      [3:0]  buckDisable,
  output logic      [3:0]  railTrigger,
  output logic             interrupt_out_n
);

  // Turns a group select into a one-hot group vector.
  function automatic logic [3:0] groupHot(input rfi_pkg::rfi_group_t sel);
    groupHot = 4'h1 << sel;
  endfunction

  logic [27:0] syncMeta;
  logic [27:0] syncLive;
  logic [15:0] buckFlags;
  logic [7:0]  monFlags;
  logic [15:0] buckMask;
  logic [5:0]  monMask;
  logic        currentLimitTriggerEnable;
  logic [3:0]  buckResidualSelect;
  logic [1:0]  monitorResidualSelect;
  logic [7:0]  buckRailGroupSelect;
  logic [1:0]  inputSupplyGroupSelect;
  logic [3:0]  monitorGroupSelect;
  logic [3:0]  groupRailTrigger;
  logic [23:0] irqEnable;
  logic [3:0]  residualHidden;

  // Two flops on every comparator pin before any logic looks at it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncMeta <= 28'h0;
      syncLive <= 28'h0;
    end else begin
      syncMeta <= {monResidualPin, monUnderPin, monOverPin, vccaUnderPin, vccaOverPin,
                   buckUnderPin, buckOverPin, buckResidualPin, buckShortPin, buckIlimPin};
      syncLive <= syncMeta;
    end
  end

  // Live fault levels after synchronisation.
  wire [3:0] buckCurrentLimitLive = syncLive[3:0];
  wire [3:0] shortLive            = syncLive[7:4];
  wire [3:0] residualLive         = syncLive[11:8];
  wire [3:0] overLive             = syncLive[15:12];
  wire [3:0] underLive            = syncLive[19:16];
  wire [7:0] monLive              = syncLive[27:20];
  wire [15:0] buckLive            = {underLive, overLive, 4'h0, buckCurrentLimitLive};

  // Register port decode.
  wire wrBuckMask = regWrite && (regAddr == `RFI_ADDR_BUCK_MASK);
  wire wrMonMask  = regWrite && (regAddr == `RFI_ADDR_MON_MASK);
  wire wrConfig   = regWrite && (regAddr == `RFI_ADDR_CONFIG);
  wire wrGroup    = regWrite && (regAddr == `RFI_ADDR_GROUP);
  wire wrRailTrig = regWrite && (regAddr == `RFI_ADDR_RAIL_TRIG);
  wire wrIrqEn    = regWrite && (regAddr == `RFI_ADDR_IRQ_EN);
  wire wrClrBuck  = regWrite && (regAddr == `RFI_ADDR_CLR_BUCK);
  wire wrClrMon   = regWrite && (regAddr == `RFI_ADDR_CLR_MON);
  wire [15:0] clrBuck = wrClrBuck ? regWdata[15:0] : 16'h0;
  wire [7:0]  clrMon  = wrClrMon ? regWdata[7:0] : 8'h0;

  // Residual voltage counts as a short only when selected.
  // [RQ5] residual select gating
  wire [3:0] residualSet = residualLive & buckResidualSelect;
  // [RQ4] short clear refusal
  wire [3:0] shortHold   = buckEnabled & buckRampDone & buckBelowShort;

  // Set terms; masked events never reach a flag, shorts have no mask.
  // [RQ3] short sets flag
  // [RQ12] mask blocks set
  wire [15:0] buckSet = {underLive & ~buckMask[15:12], overLive & ~buckMask[11:8],
                         shortLive | residualSet, buckCurrentLimitLive & ~buckMask[3:0]};
  // [RQ10] monitor residual gating
  wire [7:0]  monSet  = {monLive[7:6] & monitorResidualSelect, monLive[5:0] & ~monMask};

  // A clear is refused while the fault persists.
  // [RQ2] current limit hold
  // [RQ7] buck over under hold
  wire [15:0] buckHold = {underLive, overLive, shortHold, buckCurrentLimitLive};
  // [RQ8] supply hold
  // [RQ9] monitor hold
  wire [7:0]  monHold  = {2'b00, monLive[5:0]};

  // Set wins over clear so no event is lost.
  // [RQ13] flags keep source
  wire [15:0] next_buckFlags = buckSet | (buckFlags & ~(clrBuck & ~buckHold));
  wire [7:0]  next_monFlags  = monSet | (monFlags & ~(clrMon & ~monHold));

  // Residual-caused shorts stay hidden until the residual is gone and power-up succeeded.
  // [RQ6] residual read hiding
  wire [3:0] hideRelease = ~residualLive & {4{powerUpDone}};
  // A refused short clear must not expose a hidden flag early.
  wire [3:0] next_residualHidden = residualSet |
                                   (residualHidden & ~hideRelease & ~(clrBuck[7:4] & ~shortHold));

  // Flag and hidden state update.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buckFlags      <= 16'h0;
      monFlags       <= 8'h0;
      residualHidden <= 4'h0;
    end else begin
      buckFlags      <= next_buckFlags;
      monFlags       <= next_monFlags;
      residualHidden <= next_residualHidden;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buckMask                  <= `RFI_RST_MASK;
      monMask                   <= 6'h0;
      currentLimitTriggerEnable <= 1'b0;
      buckResidualSelect        <= 4'h0;
      monitorResidualSelect     <= 2'h0;
      buckRailGroupSelect       <= 8'h0;
      inputSupplyGroupSelect    <= 2'h0;
      monitorGroupSelect        <= 4'h0;
      groupRailTrigger          <= 4'h0;
      irqEnable                 <= `RFI_RST_IRQ_EN;
    end else begin
      if (wrBuckMask) buckMask <= regWdata[15:0] & ~`RFI_SHORT_FIELD;
      if (wrMonMask) monMask <= regWdata[5:0];
      if (wrConfig) begin
        currentLimitTriggerEnable <= regWdata[0];
        buckResidualSelect        <= regWdata[7:4];
        monitorResidualSelect     <= regWdata[9:8];
      end
      if (wrGroup) begin
        buckRailGroupSelect    <= regWdata[7:0];
        inputSupplyGroupSelect <= regWdata[9:8];
        monitorGroupSelect     <= regWdata[13:10];
      end
      if (wrRailTrig) groupRailTrigger <= regWdata[3:0];
      if (wrIrqEn) irqEnable <= regWdata[23:0];
    end
  end

  // Per-source trigger levels; current limit only when its trigger enable is set.
  // [RQ1] current limit trigger enable
  wire [3:0] buckTrig = shortLive | residualSet | overLive | underLive |
                        (buckCurrentLimitLive & {4{currentLimitTriggerEnable}});
  wire       vccaTrig = monLive[0] | monLive[1];
  wire [1:0] monTrig  = monLive[3:2] | monLive[5:4] | (monLive[7:6] & monitorResidualSelect);
  wire [6:0] srcTrig  = {monTrig, vccaTrig, buckTrig};
  wire [13:0] srcSel  = {monitorGroupSelect, inputSupplyGroupSelect, buckRailGroupSelect};

  // Each source is routed onto its group.
  wire [3:0] srcRoute [7];
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_route
      // [RQ11] group routing
      assign srcRoute[gi] = groupHot(srcSel[2*gi +: 2]) & {4{srcTrig[gi]}};
    end
  endgenerate

  // Groups combine and pass only where their trigger bit is set.
  logic [3:0] groupAny;
  always_comb begin
    groupAny = 4'h0;
    for (int k = 0; k < 7; k++) begin
      groupAny = groupAny | srcRoute[k];
    end
  end
  wire [3:0] next_railTrigger = groupAny & groupRailTrigger;

  // Short-circuit flag visible to software, with residual-caused ones hidden.
  wire [15:0] buckRead = {buckFlags[15:8], buckFlags[7:4] & ~residualHidden, buckFlags[3:0]};
  // [RQ13] single interrupt combine
  wire irqAny = |({monFlags, buckFlags} & irqEnable);

  // Read selection; unmapped and write-only offsets read as zero.
  wire [31:0] readMux =
    (regAddr == `RFI_ADDR_BUCK_FLAG) ? {16'h0, buckRead} :
    (regAddr == `RFI_ADDR_MON_FLAG)  ? {24'h0, monFlags} :
    (regAddr == `RFI_ADDR_BUCK_MASK) ? {16'h0, buckMask} :
    (regAddr == `RFI_ADDR_MON_MASK)  ? {26'h0, monMask} :
    (regAddr == `RFI_ADDR_BUCK_LIVE) ? {16'h0, buckLive} :
    (regAddr == `RFI_ADDR_MON_LIVE)  ? {26'h0, monLive[5:0]} :
    (regAddr == `RFI_ADDR_CONFIG)    ? {22'h0, monitorResidualSelect, buckResidualSelect, 3'h0,
                                        currentLimitTriggerEnable} :
    (regAddr == `RFI_ADDR_GROUP)     ? {18'h0, monitorGroupSelect, inputSupplyGroupSelect,
                                        buckRailGroupSelect} :
    (regAddr == `RFI_ADDR_RAIL_TRIG) ? {28'h0, groupRailTrigger} :
    (regAddr == `RFI_ADDR_IRQ_EN)    ? {8'h0, irqEnable} : 32'h0;

  // Output registers: read data, triggers, interrupt pin.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata        <= 32'h0;
      railTrigger     <= 4'h0;
      interrupt_out_n <= 1'b1;
    end else begin
      regRdata        <= regRead ? readMux : 32'h0;
      railTrigger     <= next_railTrigger;
      interrupt_out_n <= ~irqAny;
    end
  end

  // A set short flag keeps its rail off.
  // [RQ3] regulator disable
  assign buckDisable = buckFlags[7:4];

  // Checks on flag, trigger and pin behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ilim_flag_hold_a: assert property ( // [RQ2]
    (buckCurrentLimitLive[0] && !buckMask[0]) |=> buckFlags[0])
    else $error("current-limit flag dropped while active");
  short_flag_set_a: assert property ( // [RQ3]
    shortLive[1] |=> (buckFlags[5] && buckDisable[1]))
    else $error("short did not set flag and disable rail");
  short_clear_refused_a: assert property ( // [RQ4]
    (buckFlags[4] && shortHold[0] && wrClrBuck) |=> buckFlags[4])
    else $error("short flag cleared while rail below threshold");
  residual_ignored_a: assert property ( // [RQ5]
    (!buckResidualSelect[2] && !shortLive[2] && !buckFlags[6] && !wrConfig) |=> !buckFlags[6])
    else $error("unselected residual set short flag");
  residual_hidden_a: assert property ( // [RQ6]
    (regRead && regAddr == `RFI_ADDR_BUCK_FLAG && residualHidden[0]) |=> !regRdata[4])
    else $error("residual short readable too early");
  over_flag_hold_a: assert property ( // [RQ7]
    (buckFlags[8] && overLive[0]) |=> buckFlags[8])
    else $error("buck overvoltage flag cleared during fault");
  supply_over_set_a: assert property ( // [RQ8]
    (monLive[0] && !monMask[0]) |=> monFlags[0])
    else $error("supply overvoltage flag not set");
  monitor_under_set_a: assert property ( // [RQ9]
    (monLive[5] && !monMask[5]) |=> monFlags[5])
    else $error("monitor undervoltage flag not set");
  mon_residual_off_a: assert property ( // [RQ10]
    (!monitorResidualSelect[0] && !monFlags[6] && !wrConfig) |=> !monFlags[6])
    else $error("unselected monitor residual set flag");
  group_route_a: assert property ( // [RQ11]
    (overLive[0] && buckRailGroupSelect[1:0] == 2'h1 && groupRailTrigger[1]) |=> railTrigger[1])
    else $error("buck trigger not routed to its group");
  mask_blocks_a: assert property ( // [RQ12]
    (buckMask[8] && !buckFlags[8]) |=> !buckFlags[8])
    else $error("masked event set a flag");
  irq_pin_a: assert property ( // [RQ13]
    1'b1 |=> (interrupt_out_n == !$past(irqAny)))
    else $error("interrupt pin not low for pending flag");
  ilim_no_trigger_a: assert property ( // [RQ1]
    (!currentLimitTriggerEnable && syncLive[27:4] == 24'h0) |=> railTrigger == 4'h0)
    else $error("current limit triggered with trigger disabled");

  short_then_clear_c: cover property (buckFlags[4] ##1 wrClrBuck ##1 !buckFlags[4]);
  refused_clear_c: cover property (buckFlags[8] && overLive[0] && wrClrBuck);
  residual_release_c: cover property (residualHidden[0] ##[1:20] !residualHidden[0]);
  pin_low_c: cover property (interrupt_out_n ##1 !interrupt_out_n);

endmodule
`default_nettype wire

// file: verification/rfi_host_model.sv
// Host processor model that owns the register port of the rail fault interrupt block.
// Assumes one clock; requests change right after a rising edge and read data stand one cycle.
`default_nettype none
module rfi_host_model (
  // Clock.
  input  wire logic        clk,
  // Register port.
  output var  logic [7:0]  regAddr,
  output var  logic [31:0] regWdata,
  output var  logic        regWrite,
  output var  logic        regRead,
  input  wire logic [31:0] regRdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    regAddr = 8'h00;
    regWdata = 32'h00000000;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // One write cycle; address and data are scrambled once the strobe drops.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask

  // One read cycle; data are taken in the single cycle they stand.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(negedge clk);
    d = regRdata;
  endtask

  task automatic clear(input logic [7:0] live, input logic [7:0] clr, input logic [31:0] bits,
                       output logic [31:0] seen);
    rd(live, seen);
    wr(clr, bits);
  endtask
endmodule
`default_nettype wire

// file: verification/rail_fault_interrupt_logic_test.sv
// Self-checking bench for the rail fault interrupt logic.
// Assumes the host model drives the register port and the bench drives every fault pin.
`include "rfi_consts.svh"
`default_nettype none
module rail_fault_interrupt_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, pud = 0, vo = 0, vu = 0, irqN, regWrite, regRead;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [3:0] ilim = 0, shrt = 0, resid = 0, over = 0, under = 0, en = 0, ramp = 0, below = 0, dis, trig;
  logic [1:0] mo = 0, mu = 0, mr = 0;
  logic [31:0] g, t, s, p;
  int bad_count = 0, comparisons = 0;

  // Clock at 25 MHz.
  always #20 clk = ~clk;

  rfi_host_model rfi_host_model_i (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  rail_fault_interrupt_logic rail_fault_interrupt_logic_i (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .buckIlimPin(ilim), .buckShortPin(shrt), .buckResidualPin(resid), .buckOverPin(over),
    .buckUnderPin(under), .buckEnabled(en), .buckRampDone(ramp), .buckBelowShort(below),
    .powerUpDone(pud), .vccaOverPin(vo), .vccaUnderPin(vu), .monOverPin(mo), .monUnderPin(mu),
    .monResidualPin(mr), .buckDisable(dis), .railTrigger(trig), .interrupt_out_n(irqN));

  // Compares and counts.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    rfi_host_model_i.wr(a, v);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rfi_host_model_i.rd(a, v);
    check(v, e);
  endtask

  // Waits past synchroniser, flag and pin stages.
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask

  // Group triggers expected from buck overvoltage, supply and monitor sources.
  function automatic logic [3:0] expTrig(input logic [31:0] g, input logic [31:0] t, input logic [31:0] p,
                                         input logic [31:0] s);
    logic [3:0] r;
    r = 4'h0;
    for (int n = 0; n < 4; n++) begin
      if (p[8 + n]) r[g[2*n +: 2]] = 1'b1;
    end
    if (p[0] | p[1]) r[g[9:8]] = 1'b1;
    if (p[2] | p[4] | (p[6] & s[0])) r[g[11:10]] = 1'b1;
    if (p[3] | p[5] | (p[7] & s[1])) r[g[13:12]] = 1'b1;
    return r & t[3:0];
  endfunction

  task automatic test_done;
    $display("mismatches %0d of %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog well beyond the expected run.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done;
  end

  // Main sequence.
  initial begin
    void'($urandom(29574));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    check({31'h0, irqN}, 32'h1);
    rdChk(`RFI_ADDR_IRQ_EN, 32'h00ffffff);
    rdChk(`RFI_ADDR_BUCK_MASK, 32'h0);
    rdChk(8'h40, 32'h0);
    wr(`RFI_ADDR_RAIL_TRIG, 32'hf);
    @(posedge clk) ilim <= 4'h1;
    settle;
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h1);
    check({28'h0, trig}, 32'h0);
    check({31'h0, irqN}, 32'h0);
    wr(`RFI_ADDR_IRQ_EN, 32'h0);
    settle;
    check({31'h0, irqN}, 32'h1);
    wr(`RFI_ADDR_IRQ_EN, 32'hffffff);
    wr(`RFI_ADDR_CONFIG, 32'h1);
    settle;
    check({28'h0, trig}, 32'h1);
    rfi_host_model_i.clear(`RFI_ADDR_BUCK_LIVE, `RFI_ADDR_CLR_BUCK, 32'h1, d);
    check(d, 32'h1);
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h1);
    @(posedge clk) ilim <= 4'h0;
    settle;
    wr(`RFI_ADDR_CLR_BUCK, 32'h1);
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h0);
    // Masked over and unmasked under on separate rails.
    wr(`RFI_ADDR_BUCK_MASK, 32'h100);
    @(posedge clk) {over, under} <= 8'h12;
    settle;
    rdChk(`RFI_ADDR_BUCK_LIVE, 32'h2100);
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h2000);
    wr(8'h40, 32'hffffffff);
    wr(`RFI_ADDR_BUCK_MASK, 32'h0);
    settle;
    wr(`RFI_ADDR_BUCK_MASK, 32'h100);
    wr(`RFI_ADDR_CLR_BUCK, 32'h2100);
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h2100);
    @(posedge clk) {over, under} <= 8'h00;
    settle;
    wr(`RFI_ADDR_CLR_BUCK, 32'h2100);
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h0);
    wr(`RFI_ADDR_BUCK_MASK, 32'h0);
    // Short on rail 1 with a ramped rail still below threshold.
    @(posedge clk) {en, ramp, below, shrt} <= 16'h2222;
    settle;
    check({28'h0, trig}, 32'h1);
    @(posedge clk) shrt <= 4'h0;
    settle;
    check({28'h0, dis}, 32'h2);
    wr(`RFI_ADDR_CLR_BUCK, 32'h20);
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h20);
    @(posedge clk) below <= 4'h0;
    wr(`RFI_ADDR_CLR_BUCK, 32'h20);
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h0);
    // Residual on rail 0, first deselected, then selected.
    @(posedge clk) resid <= 4'h1;
    settle;
    check({28'h0, dis}, 32'h0);
    wr(`RFI_ADDR_CONFIG, 32'h10);
    settle;
    check({28'h0, dis}, 32'h1);
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h0);
    @(posedge clk) resid <= 4'h0;
    settle;
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h0);
    @(posedge clk) pud <= 1'b1;
    settle;
    rdChk(`RFI_ADDR_BUCK_FLAG, 32'h10);
    wr(`RFI_ADDR_CLR_BUCK, 32'h10);
    @(posedge clk) pud <= 1'b0;
    // Random buck, supply and monitor faults with random routing and monitor masks.
    for (int i = 0; i < 16; i++) begin
      g = $urandom;
      t = $urandom;
      s = $urandom;
      p = $urandom;
      wr(`RFI_ADDR_GROUP, {18'h0, g[13:0]});
      wr(`RFI_ADDR_RAIL_TRIG, {28'h0, t[3:0]});
      wr(`RFI_ADDR_MON_MASK, {26'h0, t[9:4]});
      wr(`RFI_ADDR_CONFIG, {22'h0, s[1:0], 8'h0});
      @(posedge clk) {over, mr, mu, mo, vu, vo} <= p[11:0];
      settle;
      check({28'h0, trig}, {28'h0, expTrig(g, t, p, s)});
      rdChk(`RFI_ADDR_MON_LIVE, {26'h0, p[5:0]});
      rdChk(`RFI_ADDR_MON_FLAG, {24'h0, p[7:6] & s[1:0], p[5:0] & ~t[9:4]});
      rdChk(`RFI_ADDR_BUCK_FLAG, {20'h0, p[11:8], 8'h0});
      @(posedge clk) {over, mr, mu, mo, vu, vo} <= 12'h000;
      settle;
      wr(`RFI_ADDR_CLR_MON, 32'hff);
      wr(`RFI_ADDR_CLR_BUCK, 32'hf00);
      rdChk(`RFI_ADDR_MON_FLAG, 32'h0);
      rdChk(`RFI_ADDR_BUCK_FLAG, 32'h0);
    end
    test_done;
  end
endmodule
`default_nettype wire
